// File: ccg_clock_gen.sv
// Summary of operation
// - After reset the CPU always runs from the internal high-speed oscillator.
// - Crystal main oscillator stops on stop mode or its stop bit.
// - Internal high-speed oscillator stops on stop mode or its stop bit.
// - Main clock is high-speed system clock or internal high-speed clock per main_clock_mode.
// - Subsystem oscillator stoppable by register; external subsystem pin is an alternative.
// - Low-speed oscillator always runs after reset release without software.
// - Low-speed stop request works only when the option strap allows it.
// - Low-speed clock never reaches the CPU clock selection.
// - Low-speed clock drives watchdog and the 8-bit timer when it selects it.
// - Reset loads cpu_clock_control with 01H: main clock divided by two.
// - Bit 5 reads source status, bit 4 selects source, bits 2-0 divider.
// - With source 0, codes 000-100 divide the main clock by 1 to 16.
// - With source 1, codes 000-100 give subsystem/2; other combinations prohibited.
// - Shortest instruction takes two CPU clocks.
// - Main source status reads 1 on high-speed system clock, 0 on internal.
// - A CPU clock selection change takes effect at the end of the running CPU clock period.
module ccg_clock_gen
  import ccg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Clock pins
  input  wire logic        main_crystal_pin,
  input  wire logic        ext_main_clock_pin,
  input  wire logic        sub_crystal_in_pin,
  input  wire logic        ext_sub_clock_pin,
  // CPU core side
  input  wire logic        stop_mode,
  input  wire logic        ls_stop_allowed,
  output logic             cpu_clk_en,
  output logic             cpu_instr_slot,
  // Peripheral clocks
  output logic             prs_clk_en,
  output logic             wdt_clk_en,
  input  wire logic        eight_bit_timer_ls_sel,
  output logic             eight_bit_timer_ls_en,
  // Oscillator run status
  output logic             main_osc_run,
  output logic             hs_osc_run,
  output logic             sub_osc_run,
  output logic             ls_osc_run
);

  // Register fields
  logic       cpu_source_select;
  logic [2:0] cpu_divider;
  logic       cpu_source_status;
  logic [2:0] cpu_divider_active;
  logic       ls_stop;
  logic       hs_stop;
  logic       hs_stable;
  logic [5:0] hs_settle_cnt;
  logic       periph_hs_select;
  logic       periph_select_locked;
  logic       main_source_select;
  logic       main_source_status;
  logic       main_stop;
  logic       ext_main_mode;
  logic       main_osc_enable;
  logic       ext_sub_mode;
  logic       sub_osc_enable;
  logic       amp_select;

  // Strap capture
  logic       strap_taken;
  logic       ls_stoppable;

  // Internal ticks
  logic       hs_tick;
  logic       ls_tick;
  logic       xtal_rise;
  logic       ext_main_rise;
  logic       xt1_rise;
  logic       ext_sub_rise;
  logic       fin_tick;
  logic       sub_tick;

  // Main clock mux
  ccg_mux_state_t mux_state;
  logic       main_want;
  logic       main_old_tick;
  logic       main_new_tick;
  logic       main_old_alive;
  logic       main_tick;

  // CPU divider
  logic [3:0] cpu_cnt;
  logic       cpu_src_tick;
  logic [2:0] cpu_code;
  logic       cpu_period_end;
  logic       instr_phase;

  // Write decode
  logic       wr_ccc;
  logic       wr_iom;
  logic       wr_mcm;
  logic       wr_moc;
  logic       wr_oos;
  logic       ccc_write_ok;

  assign wr_ccc = reg_wr && (reg_addr == CCG_ADDR_CPU_CLOCK_CONTROL);
  assign wr_iom = reg_wr && (reg_addr == CCG_ADDR_INTERNAL_OSC_MODE);
  assign wr_mcm = reg_wr && (reg_addr == CCG_ADDR_MAIN_CLOCK_MODE);
  assign wr_moc = reg_wr && (reg_addr == CCG_ADDR_MAIN_OSC_CONTROL);
  assign wr_oos = reg_wr && (reg_addr == CCG_ADDR_OSC_OPERATION_SELECT);

  // Prohibited divider codes leave the register untouched
  assign ccc_write_ok = (reg_wdata[CCG_CPU_DIVIDER_LSB +: 3] <= CCG_DIV_CODE_MAX);

  // Oscillator enables
  assign main_osc_run = main_osc_enable & ~main_stop & ~stop_mode;
  assign hs_osc_run   = ~hs_stop & ~stop_mode;
  assign ls_osc_run   = ~(ls_stop & ls_stoppable);
  // Subsystem clock cannot be stopped while the CPU runs on it
  assign sub_osc_run  = sub_osc_enable | cpu_source_status;

  ccg_tick_gen #(
    .DIV (CCG_HS_TICK_DIV)
  ) u_hs_osc (
    .clk  (clk),
    .rstn (rstn),
    .run  (hs_osc_run),
    .tick (hs_tick)
  );

  ccg_tick_gen #(
    .DIV (CCG_LS_TICK_DIV)
  ) u_ls_osc (
    .clk  (clk),
    .rstn (rstn),
    .run  (ls_osc_run),
    .tick (ls_tick)
  );

  ccg_pin_edge u_xtal (
    .clk  (clk),
    .rstn (rstn),
    .pin  (main_crystal_pin),
    .rise (xtal_rise)
  );

  ccg_pin_edge u_ext_main (
    .clk  (clk),
    .rstn (rstn),
    .pin  (ext_main_clock_pin),
    .rise (ext_main_rise)
  );

  ccg_pin_edge u_xt1 (
    .clk  (clk),
    .rstn (rstn),
    .pin  (sub_crystal_in_pin),
    .rise (xt1_rise)
  );

  ccg_pin_edge u_ext_sub (
    .clk  (clk),
    .rstn (rstn),
    .pin  (ext_sub_clock_pin),
    .rise (ext_sub_rise)
  );

  // High-speed system clock from crystal or external pin
  assign fin_tick = main_osc_run & (ext_main_mode ? ext_main_rise : xtal_rise);
  assign sub_tick = sub_osc_run & (ext_sub_mode ? ext_sub_rise : xt1_rise);

  // Option strap is caught once after reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_taken  <= 1'b0;
      ls_stoppable <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken  <= 1'b1;
      ls_stoppable <= ls_stop_allowed;
    end
  end

  // cpu_clock_control
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpu_source_select <= CCG_RST_CPU_CLOCK_CONTROL[CCG_CPU_SOURCE_SELECT_BIT];
      cpu_divider       <= CCG_RST_CPU_CLOCK_CONTROL[CCG_CPU_DIVIDER_LSB +: 3];
    end else if (wr_ccc && ccc_write_ok) begin
      // Bits 3 and 6 are not stored and read as zero
      cpu_source_select <= reg_wdata[CCG_CPU_SOURCE_SELECT_BIT];
      cpu_divider       <= reg_wdata[CCG_CPU_DIVIDER_LSB +: 3];
    end
  end

  // internal_osc_mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ls_stop <= CCG_RST_INTERNAL_OSC_MODE[CCG_LS_STOP_BIT];
      hs_stop <= CCG_RST_INTERNAL_OSC_MODE[CCG_HS_STOP_BIT];
    end else if (wr_iom) begin
      ls_stop <= reg_wdata[CCG_LS_STOP_BIT];
      hs_stop <= reg_wdata[CCG_HS_STOP_BIT];
    end
  end

  // High-speed oscillator settles before its status bit reads 1
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hs_settle_cnt <= 6'h00;
      hs_stable     <= CCG_RST_INTERNAL_OSC_MODE[CCG_HS_STABLE_BIT];
    end else if (!hs_osc_run) begin
      hs_settle_cnt <= 6'h00;
      hs_stable     <= 1'b0;
    end else if (hs_tick && !hs_stable) begin
      hs_settle_cnt <= hs_settle_cnt + 6'h01;
      hs_stable     <= (hs_settle_cnt == CCG_HS_SETTLE_TICKS);
    end
  end

  // main_clock_mode: peripheral select may be written once after reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      periph_hs_select     <= CCG_RST_MAIN_CLOCK_MODE[CCG_PERIPH_HS_SELECT_BIT];
      periph_select_locked <= 1'b0;
      main_source_select   <= CCG_RST_MAIN_CLOCK_MODE[CCG_MAIN_SOURCE_SELECT_BIT];
    end else if (wr_mcm) begin
      if (!periph_select_locked) begin
        periph_hs_select     <= reg_wdata[CCG_PERIPH_HS_SELECT_BIT];
        periph_select_locked <= 1'b1;
      end
      main_source_select <= reg_wdata[CCG_MAIN_SOURCE_SELECT_BIT];
    end
  end

  // main_osc_control
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      main_stop <= CCG_RST_MAIN_OSC_CONTROL[CCG_MAIN_STOP_BIT];
    end else if (wr_moc) begin
      main_stop <= reg_wdata[CCG_MAIN_STOP_BIT];
    end
  end

  // osc_operation_select
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_main_mode   <= CCG_RST_OSC_OPERATION_SELECT[CCG_EXT_MAIN_BIT];
      main_osc_enable <= CCG_RST_OSC_OPERATION_SELECT[CCG_MAIN_ENA_BIT];
      ext_sub_mode    <= CCG_RST_OSC_OPERATION_SELECT[CCG_EXT_SUB_BIT];
      sub_osc_enable  <= CCG_RST_OSC_OPERATION_SELECT[CCG_SUB_ENA_BIT];
      amp_select      <= CCG_RST_OSC_OPERATION_SELECT[CCG_AMP_BIT];
    end else if (wr_oos) begin
      ext_main_mode   <= reg_wdata[CCG_EXT_MAIN_BIT];
      main_osc_enable <= reg_wdata[CCG_MAIN_ENA_BIT];
      ext_sub_mode    <= reg_wdata[CCG_EXT_SUB_BIT];
      sub_osc_enable  <= reg_wdata[CCG_SUB_ENA_BIT];
      amp_select      <= reg_wdata[CCG_AMP_BIT];
    end
  end

  // Main clock mux: finish old period, then wait for the new source edge
  assign main_want      = periph_hs_select & main_source_select;
  assign main_old_tick  = main_source_status ? fin_tick : hs_tick;
  assign main_new_tick  = main_source_status ? hs_tick : fin_tick;
  assign main_old_alive = main_source_status ? main_osc_run : hs_osc_run;
  assign main_tick      = (mux_state == CCG_MS_RUN) & main_old_tick;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mux_state          <= CCG_MS_RUN;
      main_source_status <= 1'b0;
    end else begin
      case (mux_state)
        CCG_MS_RUN: begin
          if ((main_want != main_source_status) && (main_old_tick || !main_old_alive)) begin
            mux_state <= CCG_MS_WAIT;
          end
        end
        CCG_MS_WAIT: begin
          if (main_new_tick) begin
            mux_state          <= CCG_MS_RUN;
            main_source_status <= ~main_source_status;
          end
        end
        default: begin
          mux_state <= CCG_MS_RUN;
        end
      endcase
    end
  end

  // CPU clock: only main or subsystem ticks, never the low-speed one
  assign cpu_src_tick   = cpu_source_status ? sub_tick : main_tick;
  assign cpu_code       = cpu_source_status ? CCG_SUB_DIV_CODE : cpu_divider_active;
  assign cpu_period_end = cpu_src_tick & ccg_div_hit(cpu_cnt, cpu_code);

  // Selection is applied at the end of the running CPU period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpu_cnt            <= 4'h0;
      cpu_source_status  <= CCG_RST_CPU_CLOCK_CONTROL[CCG_CPU_SOURCE_SELECT_BIT];
      cpu_divider_active <= CCG_RST_CPU_CLOCK_CONTROL[CCG_CPU_DIVIDER_LSB +: 3];
    end else if (cpu_period_end) begin
      cpu_cnt            <= 4'h0;
      cpu_source_status  <= cpu_source_select;
      cpu_divider_active <= cpu_divider;
    end else if (cpu_src_tick) begin
      cpu_cnt <= cpu_cnt + 4'h1;
    end
  end

  // CPU clock enable and the two-clock instruction slot
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpu_clk_en     <= 1'b0;
      cpu_instr_slot <= 1'b0;
      instr_phase    <= 1'b0;
    end else begin
      cpu_clk_en     <= cpu_period_end;
      cpu_instr_slot <= cpu_period_end & instr_phase;
      if (cpu_period_end) begin
        instr_phase <= ~instr_phase;
      end
    end
  end

  // Peripheral, watchdog and timer clock enables
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prs_clk_en            <= 1'b0;
      wdt_clk_en            <= 1'b0;
      eight_bit_timer_ls_en <= 1'b0;
    end else begin
      prs_clk_en            <= periph_hs_select ? fin_tick : hs_tick;
      wdt_clk_en            <= ls_tick;
      eight_bit_timer_ls_en <= ls_tick & eight_bit_timer_ls_sel;
    end
  end

  // Read data stand in the cycle after the read strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == CCG_ADDR_CPU_CLOCK_CONTROL) begin
      reg_rdata <= {2'b00, cpu_source_status, cpu_source_select, 1'b0, cpu_divider};
    end else if (reg_addr == CCG_ADDR_INTERNAL_OSC_MODE) begin
      reg_rdata <= {hs_stable, 5'h00, ls_stop, hs_stop};
    end else if (reg_addr == CCG_ADDR_MAIN_CLOCK_MODE) begin
      reg_rdata <= {5'h00, periph_hs_select, main_source_status, main_source_select};
    end else if (reg_addr == CCG_ADDR_MAIN_OSC_CONTROL) begin
      reg_rdata <= {main_stop, 7'h00};
    end else if (reg_addr == CCG_ADDR_OSC_OPERATION_SELECT) begin
      reg_rdata <= {ext_main_mode, main_osc_enable, ext_sub_mode, sub_osc_enable,
                    3'h0, amp_select};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// File: ccg_pkg.sv
package ccg_pkg;

  // Register addresses
  localparam logic [15:0] CCG_ADDR_CPU_CLOCK_CONTROL    = 16'hfffb;
  localparam logic [15:0] CCG_ADDR_INTERNAL_OSC_MODE    = 16'hffa0;
  localparam logic [15:0] CCG_ADDR_MAIN_CLOCK_MODE      = 16'hffa1;
  localparam logic [15:0] CCG_ADDR_MAIN_OSC_CONTROL     = 16'hffa2;
  localparam logic [15:0] CCG_ADDR_OSC_OPERATION_SELECT = 16'hffef;

  // Values after reset
  localparam logic [7:0] CCG_RST_CPU_CLOCK_CONTROL    = 8'h01;
  localparam logic [7:0] CCG_RST_INTERNAL_OSC_MODE    = 8'h00;
  localparam logic [7:0] CCG_RST_MAIN_CLOCK_MODE      = 8'h00;
  localparam logic [7:0] CCG_RST_MAIN_OSC_CONTROL     = 8'h80;
  localparam logic [7:0] CCG_RST_OSC_OPERATION_SELECT = 8'h00;

  // cpu_clock_control fields
  localparam int CCG_CPU_SOURCE_STATUS_BIT = 5;
  localparam int CCG_CPU_SOURCE_SELECT_BIT = 4;
  localparam int CCG_CPU_DIVIDER_LSB       = 0;
  localparam logic [2:0] CCG_DIV_CODE_MAX  = 3'h4;
  localparam logic [2:0] CCG_SUB_DIV_CODE  = 3'h1;

  // internal_osc_mode fields
  localparam int CCG_HS_STABLE_BIT = 7;
  localparam int CCG_LS_STOP_BIT   = 1;
  localparam int CCG_HS_STOP_BIT   = 0;

  // main_clock_mode fields
  localparam int CCG_PERIPH_HS_SELECT_BIT = 2;
  localparam int CCG_MAIN_SOURCE_STATUS_BIT = 1;
  localparam int CCG_MAIN_SOURCE_SELECT_BIT = 0;

  // main_osc_control and osc_operation_select fields
  localparam int CCG_MAIN_STOP_BIT  = 7;
  localparam int CCG_EXT_MAIN_BIT   = 7;
  localparam int CCG_MAIN_ENA_BIT   = 6;
  localparam int CCG_EXT_SUB_BIT    = 5;
  localparam int CCG_SUB_ENA_BIT    = 4;
  localparam int CCG_AMP_BIT        = 0;

  // Rates and counts
  localparam int CCG_CLK_HZ         = 125_000_000;
  localparam int CCG_HS_OSC_HZ      = 8_000_000;
  localparam int CCG_LS_OSC_HZ      = 240_000;
  localparam int CCG_HS_TICK_DIV    = CCG_CLK_HZ / CCG_HS_OSC_HZ;
  localparam int CCG_LS_TICK_DIV    = CCG_CLK_HZ / CCG_LS_OSC_HZ;
  localparam logic [5:0] CCG_HS_SETTLE_TICKS = 6'h3f;
  localparam int CCG_MIN_INSTR_CLOCKS = 2;

  typedef enum logic [0:0] {CCG_MS_RUN, CCG_MS_WAIT} ccg_mux_state_t;

  // End of one divided period: low bits of the tick count all ones
  function automatic logic ccg_div_hit(input logic [3:0] cnt, input logic [2:0] code);
    logic [3:0] mask;
    mask = 4'h0;
    case (code)
      3'h1: mask = 4'h1;
      3'h2: mask = 4'h3;
      3'h3: mask = 4'h7;
      3'h4: mask = 4'hf;
      default: mask = 4'h0;
    endcase
    return (cnt & mask) == mask;
  endfunction

endpackage

// File: ccg_tick_gen.sv
module ccg_tick_gen #(
  parameter int DIV = 16
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Control
  input  wire logic run,
  // Tick out
  output logic      tick
);

  localparam logic [9:0] LAST = 10'(DIV - 1);

  logic [9:0] cnt;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt  <= 10'h000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt  <= 10'h000;
      tick <= 1'b0;
    end else if (cnt == LAST) begin
      cnt  <= 10'h000;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 10'h001;
      tick <= 1'b0;
    end
  end

endmodule

// File: ccg_pin_edge.sv
module ccg_pin_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Asynchronous pin
  input  wire logic pin,
  // Rising edge, one cycle
  output logic      rise
);

  logic sync1;
  logic sync2;
  logic sync3;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      rise  <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      sync3 <= sync2;
      rise  <= sync2 & ~sync3;
    end
  end

endmodule

// File: ccg_clock_gen_chk.sv
module ccg_clock_gen_chk
  import ccg_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Core and clocks
  input wire logic        stop_mode,
  input wire logic        cpu_clk_en,
  input wire logic        cpu_instr_slot,
  input wire logic        wdt_clk_en,
  input wire logic        eight_bit_timer_ls_sel,
  input wire logic        eight_bit_timer_ls_en,
  input wire logic        main_osc_run,
  input wire logic        hs_osc_run,
  input wire logic        ls_osc_run
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [9:0] wgap;
  logic       par;
  logic [4:0] wcap;
  // Cycles since the last low-speed tick, saturating
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) wgap <= 10'h3ff;
    else if (wdt_clk_en) wgap <= 10'h001;
    else if (wgap != 10'h3ff) wgap <= wgap + 10'h001;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) par <= 1'b0;
    else if (cpu_clk_en) par <= !par;
  end
  // Last accepted write to cpu_clock_control
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) wcap <= 5'h01;
    else if (reg_wr && reg_addr == CCG_ADDR_CPU_CLOCK_CONTROL && reg_wdata[2:0] <= 3'h4)
      wcap <= reg_wdata[4:0];
  end
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  cpu_read_a: assert property (reg_rd && reg_addr == CCG_ADDR_CPU_CLOCK_CONTROL |=>
    {reg_rdata[7:6], reg_rdata[4:0]} == {2'h0, wcap[4], 1'b0, wcap[2:0]})
    else $error("cpu_clock_control read wrong");
  boot_cpu_a: assert property ($rose(rstn) |-> ##[1:40] cpu_clk_en)
    else $error("no cpu clock after reset");
  ls_boot_a: assert property ($rose(rstn) |-> ls_osc_run [*8])
    else $error("low-speed osc not running after reset");
  cpu_glitch_a: assert property (cpu_clk_en |=> !cpu_clk_en)
    else $error("cpu clock pulses back to back");
  slot_pair_a: assert property (cpu_instr_slot == (cpu_clk_en && par))
    else $error("instruction slot misplaced");
  wdt_rate_a: assert property (wdt_clk_en |-> wgap >= 10'h208)
    else $error("watchdog ticks too close");
  timer_gate_a: assert property
    (eight_bit_timer_ls_en == (wdt_clk_en && $past(eight_bit_timer_ls_sel)))
    else $error("timer low-speed gate wrong");
  stop_osc_a: assert property (stop_mode |-> !hs_osc_run && !main_osc_run)
    else $error("oscillator runs in stop mode");
  cover property (reg_rd && reg_addr == CCG_ADDR_CPU_CLOCK_CONTROL ##1 reg_rdata[5]);
  cover property (eight_bit_timer_ls_en);
  cover property (stop_mode && !hs_osc_run);
endmodule

bind ccg_clock_gen ccg_clock_gen_chk u_chk (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .stop_mode, .cpu_clk_en, .cpu_instr_slot, .wdt_clk_en,
  .eight_bit_timer_ls_sel, .eight_bit_timer_ls_en, .main_osc_run, .hs_osc_run, .ls_osc_run);

// File: ccg_cpu_partner.sv
module ccg_cpu_partner (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rstn,
  // Generated CPU clock
  input  wire logic   cpu_clk_en,
  // Oscillator pins
  output logic        main_crystal_pin,
  output logic        sub_crystal_in_pin,
  output logic        ext_main_clock_pin,
  output logic        ext_sub_clock_pin,
  // Measured CPU period
  output logic [15:0] cpu_gap,
  output logic [15:0] pulse_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] run;
  // External clock inputs: 80 ns main and 128 ns subsystem, off the core clock edges
  initial begin
    ext_main_clock_pin = 1'b0;
    #3;
    forever #40 ext_main_clock_pin = ~ext_main_clock_pin;
  end
  initial begin
    ext_sub_clock_pin = 1'b0;
    #5;
    forever #64 ext_sub_clock_pin = ~ext_sub_clock_pin;
  end
  // Crystals: 48 ns and 96 ns, off the core clock edges
  initial begin
    main_crystal_pin = 1'b0;
    #3;
    forever #24 main_crystal_pin = ~main_crystal_pin;
  end
  initial begin
    sub_crystal_in_pin = 1'b0;
    #5;
    forever #48 sub_crystal_in_pin = ~sub_crystal_in_pin;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run       <= 16'h0;
      cpu_gap   <= 16'h0;
      pulse_cnt <= 16'h0;
    end else if (cpu_clk_en) begin
      cpu_gap   <= run + 16'h1;
      run       <= 16'h0;
      pulse_cnt <= pulse_cnt + 16'h1;
    end else begin
      run <= run + 16'h1;
    end
  end
endmodule

// File: cpu_clock_generator_select_tb_top.sv
module cpu_clock_generator_select_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ccg_pkg::*;
  localparam logic [15:0] CPU = CCG_ADDR_CPU_CLOCK_CONTROL;
  localparam logic [15:0] RA [6] = '{CPU, CCG_ADDR_INTERNAL_OSC_MODE,
    CCG_ADDR_MAIN_CLOCK_MODE, CCG_ADDR_MAIN_OSC_CONTROL, CCG_ADDR_OSC_OPERATION_SELECT,
    16'hff00};
  localparam logic [7:0] RV [6] = '{8'h01, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
  logic clk, rstn, reg_wr, reg_rd, stop_mode, ls_stop_allowed, eight_bit_timer_ls_sel;
  logic [15:0] reg_addr, gap, pcnt;
  logic [7:0] reg_wdata, reg_rdata;
  logic cpu_clk_en, wdt_clk_en, eight_bit_timer_ls_en, prs_clk_en;
  logic main_osc_run, hs_osc_run, sub_osc_run, ls_osc_run;
  logic main_crystal_pin, ext_main_clock_pin, sub_crystal_in_pin, ext_sub_clock_pin;
  int error_cnt, check_count;

  ccg_clock_gen DUT (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .main_crystal_pin, .ext_main_clock_pin, .sub_crystal_in_pin, .ext_sub_clock_pin,
    .stop_mode, .ls_stop_allowed, .cpu_clk_en, .cpu_instr_slot(), .prs_clk_en,
    .wdt_clk_en, .eight_bit_timer_ls_sel, .eight_bit_timer_ls_en, .main_osc_run,
    .hs_osc_run, .sub_osc_run, .ls_osc_run);
  ccg_cpu_partner u_cpu (.clk, .rstn, .cpu_clk_en, .main_crystal_pin, .sub_crystal_in_pin,
    .ext_main_clock_pin, .ext_sub_clock_pin, .cpu_gap(gap), .pulse_cnt(pcnt));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic summarize();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    error_cnt++;
    $display("BAD %0t wait expired", $time);
    summarize();
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rraw(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] v;
    rraw(a, v);
    chk(v, e);
  endtask
  // Software waits for a status field before going on
  task automatic poll(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    int t;
    t = 0;
    rraw(a, v);
    while ((v & m) !== e && t < 200) begin
      rraw(a, v);
      t++;
    end
    if ((v & m) !== e) hang();
  endtask
  task automatic pulses(input int n);
    logic [15:0] s;
    int t;
    s = pcnt;
    t = 0;
    while (pcnt < s + 16'(n) && t < 20000) begin
      @(posedge clk);
      #1;
      t++;
    end
    if (pcnt < s + 16'(n)) hang();
  endtask
  // Pulses seen over n cycles: peripheral clock or timer low-speed gate
  task automatic hits(input int n, input logic prs, output logic [15:0] h);
    h = 16'h0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if ((prs ? prs_clk_en : eight_bit_timer_ls_en) === 1'b1) h++;
    end
  endtask

  initial begin
    logic [15:0] h;
    error_cnt = 0;
    check_count = 0;
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0;
    reg_wdata = 8'h0;
    stop_mode = 1'b0;
    ls_stop_allowed = 1'b0;
    eight_bit_timer_ls_sel = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(RA[i], RV[i]);
    pulses(3);
    chk(gap, 16'(CCG_HS_TICK_DIV * 2));
    hits(10 * CCG_HS_TICK_DIV, 1'b1, h);
    chk(h, 16'h000a);
    wr(CPU, 8'h48);
    rd(CPU, 8'h00);
    for (int c = 0; c < 5; c++) begin
      wr(CPU, 8'(c));
      pulses(3);
      chk(gap, 16'(CCG_HS_TICK_DIV << c));
    end
    wr(CPU, 8'h05);
    rd(CPU, 8'h04);
    wr(CPU, 8'h01);
    eight_bit_timer_ls_sel <= 1'b1;
    hits(CCG_LS_TICK_DIV, 1'b0, h);
    chk(h, 16'h1);
    eight_bit_timer_ls_sel <= 1'b0;
    hits(2 * CCG_LS_TICK_DIV, 1'b0, h);
    chk(h, 16'h0);
    rd(CCG_ADDR_INTERNAL_OSC_MODE, 8'h80);
    wr(CCG_ADDR_INTERNAL_OSC_MODE, 8'h02);
    chk(ls_osc_run, 1'b1);
    wr(CCG_ADDR_OSC_OPERATION_SELECT, 8'h10);
    chk(sub_osc_run, 1'b1);
    pulses(1);
    wr(CPU, 8'h10);
    rd(CPU, 8'h10);
    poll(CPU, 8'h20, 8'h20);
    pulses(3);
    chk(gap, 16'h18);
    wr(CPU, 8'h14);
    pulses(3);
    chk(gap, 16'h18);
    wr(CCG_ADDR_OSC_OPERATION_SELECT, 8'h30);
    pulses(3);
    chk(gap, 16'h20);
    rd(CPU, 8'h34);
    wr(CCG_ADDR_OSC_OPERATION_SELECT, 8'h50);
    wr(CCG_ADDR_MAIN_OSC_CONTROL, 8'h00);
    chk(main_osc_run, 1'b1);
    wr(CCG_ADDR_MAIN_CLOCK_MODE, 8'h05);
    poll(CCG_ADDR_MAIN_CLOCK_MODE, 8'h02, 8'h02);
    hits(60, 1'b1, h);
    chk(h, 16'h000a);
    wr(CPU, 8'h01);
    poll(CPU, 8'h20, 8'h00);
    pulses(3);
    chk(gap, 16'h0c);
    wr(CCG_ADDR_OSC_OPERATION_SELECT, 8'hd0);
    pulses(3);
    chk(gap, 16'h14);
    wr(CCG_ADDR_MAIN_CLOCK_MODE, 8'h04);
    poll(CCG_ADDR_MAIN_CLOCK_MODE, 8'h02, 8'h00);
    wr(CCG_ADDR_MAIN_OSC_CONTROL, 8'h80);
    chk(main_osc_run, 1'b0);
    @(posedge clk);
    stop_mode <= 1'b1;
    #1;
    chk(hs_osc_run, 1'b0);
    @(posedge clk);
    stop_mode <= 1'b0;
    wr(CCG_ADDR_INTERNAL_OSC_MODE, 8'h01);
    chk(hs_osc_run, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    h = pcnt;
    repeat (100) @(posedge clk);
    chk(pcnt - h, 16'h0);
    @(posedge clk);
    rstn <= 1'b0;
    ls_stop_allowed <= 1'b1;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(CPU, 8'h01);
    pulses(2);
    chk(gap, 16'(CCG_HS_TICK_DIV * 2));
    wr(CCG_ADDR_INTERNAL_OSC_MODE, 8'h02);
    chk(ls_osc_run, 1'b0);
    summarize();
  end
endmodule
